/* logic/ecp_top.sv */
// Two edge counters with prescalers, pin synchronisers, sample-clocked
// capture FIFOs and a classic Wishbone register slave.
// Assumes one 200 MHz clock; every pin is asynchronous to it.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Each counter's wrap pulse and output can gate the other counter.
// - Chained counters behave as one 64-bit counter.
// - Prescaler offers divide by eight, divide by two or off.
// - Prescaler wraps after eight or two edges; main count steps per wrap.
// - Prescaler residue is not readable.
// - Prescaled counts may be low by seven or one ticks.
// - Prescaling applies only to the external source pin.
// - Main counter is 32 bits, counting up or down on source edges.
// - Gate and other inputs are synchronised before reaching the counter.
// - Fast mode samples inputs on edges, counts on the third edge.
// - Slow mode samples on a delayed source, counts on the next edge.
// - Edges count only while armed; rising or falling edge selectable.
// - Count reads never disturb counting.
// - Active pause ignores source edges; counting resumes afterwards.
// - Pause comes from the gate input with selectable active level.
// - Each active sample clock edge while armed pushes the count into the FIFO unless it is full.
// - Samples are cumulative; sample edges never clear the counter.
// - Sample clock edge polarity is selectable.
// - Counting starts at arm, before the first sample edge.
// - Direction is up, down, or follows the direction input.
module ecp_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] src_pin_i,
    input wire logic [1:0] gate_pin_i,
    input wire logic [1:0] dir_pin_i,
    input wire logic [1:0] hardware_arm_input_i,
    input wire logic [1:0] smp_clk_i,
    output logic [1:0][31:0] smp_data_o,
    output logic [1:0] smp_valid_o,
    input wire logic [1:0] smp_ready_i,
    output logic [1:0] terminal_count_pulse_o,
    output logic [1:0] int_out_o
);
    typedef struct packed {
        logic [1:0][4:0] sy1;
        logic [1:0][4:0] sy2;
        logic [1:0][4:0] prv;
        logic [2:0][18:0] tb_acc;
        logic [2:0] tb_tick;
        logic [1:0][15:0] cfg;
        logic [1:0] armed;
        logic [1:0] ovf;
        logic [1:0] tick;
        logic [1:0] up;
        logic [1:0] clr;
        logic [1:0] p1v;
        logic [1:0] p1p;
        logic [1:0] p1u;
        logic [1:0] p2v;
        logic [1:0] p2p;
        logic [1:0] p2u;
        logic [1:0] dly;
        logic [1:0] pend;
        logic [1:0] hp;
        logic [1:0] hu;
        logic [1:0][3:0][31:0] mem;
        logic [1:0][2:0] wp;
        logic [1:0][2:0] rp;
        logic ack;
        logic [31:0] rdat;
    } ecp_top_state_t;

    ecp_top_state_t q, d;
    logic [1:0][31:0] cnt_w;
    logic [1:0] tc_w;
    logic [1:0] tcdn_w;
    logic [1:0] out_w;

    ////////////////////////////////////////////////////////////////////
    // Counter cores

    ecp_cnt_if cif[2] ();

    for (genvar i = 0; i < 2; i++) begin : g_ch
        assign cif[i].tick = q.tick[i];
        assign cif[i].up = q.up[i];
        assign cif[i].armed = q.armed[i];
        assign cif[i].clear = q.clr[i];
        // Timebases are too fast or too slow to divide usefully
        assign cif[i].presc =
            (q.cfg[i][ecp_pkg::CFG_SRC_LSB +: 3] == ecp_pkg::ECP_SRC_PIN) ?
            ecp_pkg::ecp_pre_t'(q.cfg[i][ecp_pkg::CFG_PRE_LSB +: 2]) :
            ecp_pkg::ECP_PRE_OFF;
        assign cnt_w[i] = cif[i].count;
        assign tc_w[i] = cif[i].tc;
        assign tcdn_w[i] = cif[i].tc_dn;
        assign out_w[i] = cif[i].int_out;
        assign smp_valid_o[i] = q.wp[i] != q.rp[i];
        assign smp_data_o[i] = q.mem[i][q.rp[i][1:0]];

        ecp_counter u_cnt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cnt_if(cif[i])
        );
    end

    assign terminal_count_pulse_o = tc_w;
    assign int_out_o = out_w;
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;

    function automatic logic [18:0] tb_khz(input int t);
        case (t)
            0: tb_khz = ecp_pkg::TB_FAST_KHZ;
            1: tb_khz = ecp_pkg::TB_MID_KHZ;
            default: tb_khz = ecp_pkg::TB_SLOW_KHZ;
        endcase
    endfunction : tb_khz

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [1:0] arm_sw;
        logic [1:0] disarm_sw;
        logic [1:0] ovf_clr;
        logic [4:0] rise;
        logic [4:0] fall;
        logic [18:0] acc;
        logic [4:0] off;
        logic wc;
        logic req;
        logic ev;
        logic gate;
        logic pz;
        logic upn;
        logic sck;
        logic full;
        int p;
        ecp_pkg::ecp_src_t src;
        arm_sw = 2'h0;
        disarm_sw = 2'h0;
        ovf_clr = 2'h0;
        rise = 5'h00;
        fall = 5'h00;
        acc = 19'h00000;
        off = {wb_adr_i[4:2], 2'h0};
        wc = wb_adr_i[5];
        req = wb_cyc_i && wb_stb_i && !q.ack;
        ev = 1'b0;
        gate = 1'b0;
        pz = 1'b0;
        upn = 1'b0;
        sck = 1'b0;
        full = 1'b0;
        p = 0;
        src = ecp_pkg::ECP_SRC_PIN;
        d = q;
        d.tick = 2'h0;
        d.clr = 2'h0;
        d.tb_tick = 3'h0;
        d.dly = 2'h0;

        // Internal timebases as one-cycle enables
        for (int t = 0; t < 3; t++) begin
            acc = q.tb_acc[t] + tb_khz(t);
            if (acc >= ecp_pkg::CLK_KHZ) begin
                d.tb_acc[t] = acc - ecp_pkg::CLK_KHZ;
                d.tb_tick[t] = 1'b1;
            end else begin
                d.tb_acc[t] = acc;
            end
        end

        // Register slave; every access is answered, unmapped reads zero
        d.ack = req;
        d.rdat = 32'h0;
        if (req && wb_adr_i[7:6] == 2'h0) begin
            if (off == ecp_pkg::REG_CTRL) begin
                if (wb_we_i && wb_sel_i[0]) begin
                    arm_sw[wc] = wb_dat_i[ecp_pkg::CTRL_ARM];
                    disarm_sw[wc] = wb_dat_i[ecp_pkg::CTRL_DISARM];
                end
            end else if (off == ecp_pkg::REG_CFG) begin
                for (int b = 0; b < 2; b++) begin
                    if (wb_we_i && wb_sel_i[b]) begin
                        d.cfg[wc][b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
                d.rdat = {16'h0000, q.cfg[wc]};
            end else if (off == ecp_pkg::REG_COUNT) begin
                // Read side only samples the count
                d.rdat = cnt_w[wc];
            end else if (off == ecp_pkg::REG_STAT) begin
                if (wb_we_i && wb_sel_i[0]) begin
                    ovf_clr[wc] = wb_dat_i[ecp_pkg::STAT_OVF];
                end
                d.rdat[ecp_pkg::STAT_ARMED] = q.armed[wc];
                d.rdat[ecp_pkg::STAT_OVF] = q.ovf[wc];
                d.rdat[ecp_pkg::STAT_LVL_LSB +: 3] = q.wp[wc] - q.rp[wc];
            end
        end

        for (int c = 0; c < 2; c++) begin
            p = 1 - c;
            // Two-stage synchronisers on every pin
            d.sy1[c] = {smp_clk_i[c], hardware_arm_input_i[c],
                        dir_pin_i[c], gate_pin_i[c], src_pin_i[c]};
            d.sy2[c] = q.sy1[c];
            d.prv[c] = q.sy2[c];
            rise = q.sy2[c] & ~q.prv[c];
            fall = ~q.sy2[c] & q.prv[c];

            // Source edge
            src = ecp_pkg::ecp_src_t'(q.cfg[c][ecp_pkg::CFG_SRC_LSB +: 3]);
            case (src)
                ecp_pkg::ECP_SRC_PIN: begin
                    ev = q.cfg[c][ecp_pkg::CFG_EDGE_FALL] ?
                         fall[ecp_pkg::PIN_SRC] :
                         rise[ecp_pkg::PIN_SRC];
                end
                ecp_pkg::ECP_SRC_TB_FAST: ev = q.tb_tick[0];
                ecp_pkg::ECP_SRC_TB_MID: ev = q.tb_tick[1];
                ecp_pkg::ECP_SRC_TB_SLOW: ev = q.tb_tick[2];
                ecp_pkg::ECP_SRC_CHAIN: ev = tc_w[p];
                default: ev = 1'b0;
            endcase

            // Gate and pause level
            case (q.cfg[c][ecp_pkg::CFG_GATE_LSB +: 2])
                ecp_pkg::ECP_GATE_PEER_TC: gate = tc_w[p];
                ecp_pkg::ECP_GATE_PEER_OUT: gate = out_w[p];
                default: gate = q.sy2[c][ecp_pkg::PIN_GATE];
            endcase
            pz = q.cfg[c][ecp_pkg::CFG_PAUSE_EN] &&
                 (gate == q.cfg[c][ecp_pkg::CFG_PAUSE_HI]);

            // Direction
            case (q.cfg[c][ecp_pkg::CFG_DIR_LSB +: 2])
                ecp_pkg::ECP_DIR_UP: upn = 1'b1;
                ecp_pkg::ECP_DIR_DOWN: upn = 1'b0;
                default: upn = q.sy2[c][ecp_pkg::PIN_DIR];
            endcase

            if (src == ecp_pkg::ECP_SRC_CHAIN) begin
                // Peer wrap is already on this clock: no sync pipe, and the
                // upper half steps two clocks after the lower one wraps,
                // and in the direction the lower half wrapped
                d.tick[c] = ev && !pz;
                d.up[c] = !tcdn_w[p];
            end else if (q.cfg[c][ecp_pkg::CFG_SLOW_SYNC]) begin
                // Delayed copy of the source is one clock later
                d.dly[c] = ev;
                if (ev && q.pend[c]) begin
                    d.tick[c] = !q.hp[c];
                    d.up[c] = q.hu[c];
                    d.pend[c] = 1'b0;
                end
                if (q.dly[c]) begin
                    d.pend[c] = 1'b1;
                    d.hp[c] = pz;
                    d.hu[c] = upn;
                end
            end else if (ev) begin
                // Third-edge pipeline; one slot per edge, none dropped
                d.tick[c] = q.p2v[c] && !q.p2p[c];
                d.up[c] = q.p2u[c];
                d.p2v[c] = q.p1v[c];
                d.p2p[c] = q.p1p[c];
                d.p2u[c] = q.p1u[c];
                d.p1v[c] = 1'b1;
                d.p1p[c] = pz;
                d.p1u[c] = upn;
            end

            // Arm starts the count from zero, disarm freezes it
            if (arm_sw[c] || (q.cfg[c][ecp_pkg::CFG_HWARM_EN] &&
                rise[ecp_pkg::PIN_ARM])) begin
                d.armed[c] = 1'b1;
                d.clr[c] = 1'b1;
                d.p1v[c] = 1'b0;
                d.p2v[c] = 1'b0;
                d.pend[c] = 1'b0;
            end else if (disarm_sw[c]) begin
                d.armed[c] = 1'b0;
            end

            // Sample capture into the channel FIFO
            sck = q.cfg[c][ecp_pkg::CFG_SCLK_FALL] ?
                  fall[ecp_pkg::PIN_SCLK] :
                  rise[ecp_pkg::PIN_SCLK];
            full = (q.wp[c][2] != q.rp[c][2]) &&
                   (q.wp[c][1:0] == q.rp[c][1:0]);
            if (q.wp[c] != q.rp[c] && smp_ready_i[c]) begin
                d.rp[c] = q.rp[c] + 3'h1;
            end
            if (ovf_clr[c]) begin
                d.ovf[c] = 1'b0;
            end
            if (sck && q.cfg[c][ecp_pkg::CFG_BUF_EN] && q.armed[c]) begin
                // A full FIFO drops the sample and flags it; set wins
                if (full) begin
                    d.ovf[c] = 1'b1;
                end else begin
                    // Capture only copies; the counter is not touched
                    d.mem[c][q.wp[c][1:0]] = cnt_w[c];
                    d.wp[c] = q.wp[c] + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.cfg <= {ecp_pkg::CFG_RESET, ecp_pkg::CFG_RESET};
        end else begin
            q <= d;
        end
    end
endmodule : ecp_top
`default_nettype wire

/* logic/ecp_pkg.sv */
// Shared constants and types for the two-channel edge counter.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone bus.
package ecp_pkg;
    localparam int CNT_W = 32;
    localparam int NUM_CH = 2;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_AW = 2;
    // Register map: one 0x20 window per channel, bit 5 picks the channel
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_CFG = 5'h04;
    localparam logic [4:0] REG_COUNT = 5'h08;
    localparam logic [4:0] REG_STAT = 5'h0c;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    // Control bits, both self-clearing commands
    localparam int CTRL_ARM = 0;
    localparam int CTRL_DISARM = 1;
    // Configuration fields
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_PRE_LSB = 3;
    localparam int CFG_EDGE_FALL = 5;
    localparam int CFG_DIR_LSB = 6;
    localparam int CFG_PAUSE_EN = 8;
    localparam int CFG_PAUSE_HI = 9;
    localparam int CFG_GATE_LSB = 10;
    localparam int CFG_SCLK_FALL = 12;
    localparam int CFG_BUF_EN = 13;
    localparam int CFG_SLOW_SYNC = 14;
    localparam int CFG_HWARM_EN = 15;
    // Status fields
    localparam int STAT_ARMED = 0;
    localparam int STAT_OVF = 1;
    localparam int STAT_LVL_LSB = 4;
    // Bit positions of the synchronised pins of one channel
    localparam int PIN_SRC = 0;
    localparam int PIN_GATE = 1;
    localparam int PIN_DIR = 2;
    localparam int PIN_ARM = 3;
    localparam int PIN_SCLK = 4;
    // Prescaler wrap points, counted from zero
    localparam logic [2:0] PRE_LIM_DIV2 = 3'h1;
    localparam logic [2:0] PRE_LIM_DIV8 = 3'h7;
    // Timebases by phase accumulation, in kHz: 200000, 80000, 20000, 100
    localparam logic [18:0] CLK_KHZ = 19'h30d40;
    localparam logic [18:0] TB_FAST_KHZ = 19'h13880;
    localparam logic [18:0] TB_MID_KHZ = 19'h04e20;
    localparam logic [18:0] TB_SLOW_KHZ = 19'h00064;
    typedef enum logic [2:0] {
        ECP_SRC_PIN, ECP_SRC_TB_FAST, ECP_SRC_TB_MID, ECP_SRC_TB_SLOW,
        ECP_SRC_CHAIN
    } ecp_src_t;
    typedef enum logic [1:0] {ECP_PRE_OFF, ECP_PRE_DIV2, ECP_PRE_DIV8} ecp_pre_t;
    typedef enum logic [1:0] {ECP_DIR_UP, ECP_DIR_DOWN, ECP_DIR_PIN} ecp_dir_t;
    typedef enum logic [1:0] {
        ECP_GATE_PIN, ECP_GATE_PEER_TC, ECP_GATE_PEER_OUT
    } ecp_gate_t;
endpackage : ecp_pkg

/* logic/ecp_cnt_if.sv */
// Link between the channel control logic and one counter core.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface ecp_cnt_if;
    logic tick;
    logic up;
    logic armed;
    logic clear;
    ecp_pkg::ecp_pre_t presc;
    logic [31:0] count;
    logic tc;
    logic tc_dn;
    logic int_out;
    modport ctl (output tick, up, armed, clear, presc,
                 input count, tc, tc_dn, int_out);
    modport cnt (input tick, up, armed, clear, presc,
                 output count, tc, tc_dn, int_out);
endinterface : ecp_cnt_if
`default_nettype wire

/* logic/ecp_counter.sv */
// One 32-bit counter core with its prescaler.
// Assumes ticks arrive already synchronised and pause-gated.
`timescale 1ns/100ps
`default_nettype none
module ecp_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    ecp_cnt_if.cnt cnt_if
);
    typedef struct packed {
        logic [2:0] pre;
        logic [31:0] cnt;
        logic tc;
        logic tc_dn;
        logic tog;
    } ecp_cnt_st_t;

    ecp_cnt_st_t q, d;
    logic [2:0] lim;

    always_comb begin
        d = q;
        d.tc = 1'b0;
        d.tc_dn = 1'b0;
        case (cnt_if.presc)
            ecp_pkg::ECP_PRE_DIV2: lim = ecp_pkg::PRE_LIM_DIV2;
            ecp_pkg::ECP_PRE_DIV8: lim = ecp_pkg::PRE_LIM_DIV8;
            default: lim = 3'h0;
        endcase
        if (cnt_if.clear) begin
            d.pre = 3'h0;
            d.cnt = 32'h0;
        end else if (cnt_if.armed && cnt_if.tick) begin
            if (q.pre >= lim) begin
                d.pre = 3'h0;
                if (cnt_if.up) begin
                    d.cnt = q.cnt + 32'h1;
                    d.tc = &q.cnt;
                end else begin
                    d.cnt = q.cnt - 32'h1;
                    d.tc = ~|q.cnt;
                    d.tc_dn = ~|q.cnt;
                end
            end else begin
                d.pre = q.pre + 3'h1;
            end
        end
        // Internal output toggles on every wrap
        d.tog = q.tog ^ d.tc;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Residue in pre is never exported, so software cannot see it
    assign cnt_if.count = q.cnt;
    assign cnt_if.tc = q.tc;
    assign cnt_if.tc_dn = q.tc_dn;
    assign cnt_if.int_out = q.tog;
endmodule : ecp_counter
`default_nettype wire

/* sim/ecp_top_asserts.sv */
// Checker for the edge counter top: bus answer, wrap pulse, sample FIFO.
// Assumes it is bound to ecp_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ecp_top_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] smp_clk_i,
    input wire logic [1:0][31:0] smp_data_o,
    input wire logic [1:0] smp_valid_o,
    input wire logic [1:0] smp_ready_i,
    input wire logic [1:0] terminal_count_pulse_o,
    input wire logic [1:0] int_out_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // Cycles since the sample pin last moved, saturating at 15
    logic [3:0] age_q;
    logic prev_q;
    logic hold;
    assign hold = smp_valid_o[0] && !smp_ready_i[0] && !wb_cyc_i;
    always_ff @(posedge clk_i) begin
        prev_q <= smp_clk_i[0];
        if (rst_i || smp_clk_i[0] != prev_q) begin
            age_q <= 4'h0;
        end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
        end
    end
    ////////////////////////////////////////
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack one cycle after request");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_TC_ONE: assert property (
        terminal_count_pulse_o[0] |=> !terminal_count_pulse_o[0])
        else $error("wrap pulse too long");
    AST_INT_CAUSE: assert property (
        $changed(int_out_o[0]) |-> terminal_count_pulse_o[0]
        || $past(terminal_count_pulse_o[0]))
        else $error("output toggled without wrap");
    AST_TC_INT: assert property (
        $rose(terminal_count_pulse_o[0]) |-> ##[0:1] $changed(int_out_o[0]))
        else $error("wrap did not toggle output");
    AST_SMP_HOLD: assert property (hold |=> smp_valid_o[0])
        else $error("sample lost before pop");
    AST_SMP_DATA: assert property (hold |=> $stable(smp_data_o[0]))
        else $error("head sample changed before pop");
    AST_SMP_SOON: assert property (
        $rose(smp_valid_o[0]) |-> age_q <= 4'h8)
        else $error("capture without recent sample edge");
    AST_SMP_SYNC: assert property (
        age_q == 4'hf && $changed(smp_clk_i[0])
        |=> (!$rose(smp_valid_o[0]))[*2])
        else $error("capture faster than synchroniser");
endmodule : ecp_top_asserts
bind ecp_top ecp_top_asserts u_asserts (.*);
`default_nettype wire

/* sim/ecp_pins.sv */
// Far-side pin model: source, gate, direction, arm and sample clock.
// Assumes clk_i is the bench clock; pins move just after its edge.
`timescale 1ns/100ps
`default_nettype none
module ecp_pins (
    input wire logic clk_i,
    output logic [1:0] src_o,
    output logic [1:0] gate_o,
    output logic [1:0] dir_o,
    output logic [1:0] arm_o,
    output logic [1:0] smp_o
);
    initial begin
        src_o = 2'h0;
        gate_o = 2'h0;
        dir_o = 2'h0;
        arm_o = 2'h0;
        smp_o = 2'h0;
    end
    ////////////////////////////////////////
    // Four cycles per level so the slow sync mode sees every edge
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            @(posedge clk_i);
            src_o[ch] <= 1'h1;
            repeat (4) @(posedge clk_i);
            src_o[ch] <= 1'h0;
            repeat (3) @(posedge clk_i);
        end
    endtask : pulse
    task automatic lv(input int ch, input logic g, input logic d);
        @(posedge clk_i);
        gate_o[ch] <= g;
        dir_o[ch] <= d;
        repeat (8) @(posedge clk_i);
    endtask : lv
    task automatic hw_arm(input int ch);
        @(posedge clk_i);
        arm_o[ch] <= 1'h1;
        repeat (4) @(posedge clk_i);
        arm_o[ch] <= 1'h0;
        repeat (8) @(posedge clk_i);
    endtask : hw_arm
    task automatic smp_set(input int ch, input logic v);
        @(posedge clk_i);
        smp_o[ch] <= v;
        // Long hold lets the checker's age counter saturate between edges
        repeat (16) @(posedge clk_i);
    endtask : smp_set
endmodule : ecp_pins
`default_nettype wire

/* sim/edge_counter_with_prescaler_bench.sv */
// Self-checking bench for the two-channel edge counter.
// Assumes ecp_top, ecp_pins and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("[ERR] %0t got %h want %h", $time, g, e); \
    end \
end
module edge_counter_with_prescaler_bench;
    logic clk, rst, cyc, stb, wen, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, c1, c2;
    logic [1:0] src, gate, dir, arm, smp, vld, rdy, tc, iout;
    logic [1:0][31:0] sdat;
    int fail_count = 0;
    int checks_done = 0;
    int tc_seen = 0;
    ecp_pins MODEL (.clk_i(clk), .src_o(src), .gate_o(gate), .dir_o(dir),
        .arm_o(arm), .smp_o(smp));
    ecp_top DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .src_pin_i(src),
        .gate_pin_i(gate), .dir_pin_i(dir), .hardware_arm_input_i(arm),
        .smp_clk_i(smp), .smp_data_o(sdat), .smp_valid_o(vld),
        .smp_ready_i(rdy), .terminal_count_pulse_o(tc), .int_out_o(iout));
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tc[0] === 1'h1) begin
            tc_seen++;
        end
    end
    ////////////////////////////////////////
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        wen <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        // Ack comes one cycle after the edge that takes the request
        `CHK(n, 2)
    endtask : wb
    task automatic wr(input int ch, input logic [7:0] o, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, 8'(ch * 32) + o, d, q);
    endtask : wr
    task automatic rd(input int ch, input logic [7:0] o, output logic [31:0] q);
        wb(1'h0, 8'(ch * 32) + o, 32'h0, q);
    endtask : rd
    // Settling first lets synchronised edges land before the read
    task automatic cnt(input int ch, output logic [31:0] q);
        repeat (20) @(posedge clk);
        rd(ch, ecp_pkg::REG_COUNT, q);
    endtask : cnt
    function automatic logic [31:0] f(int v, int p);
        return 32'(v) << p;
    endfunction : f
    task automatic go(input int ch, input logic [31:0] cfg);
        wr(ch, ecp_pkg::REG_CFG, cfg);
        wr(ch, ecp_pkg::REG_CTRL, f(1, ecp_pkg::CTRL_ARM));
    endtask : go
    // Deltas only, so the sync pipeline lag never enters the sums
    task automatic step(input int ch, input int n, input logic [31:0] e);
        cnt(ch, c1);
        MODEL.pulse(ch, n);
        cnt(ch, c2);
        `CHK(c2 - c1, e)
    endtask : step
    task automatic pop;
        @(posedge clk);
        rdy <= 2'h1;
        @(posedge clk);
        rdy <= 2'h0;
        repeat (2) @(posedge clk);
    endtask : pop
    ////////////////////////////////////////
    task automatic t_reset;
        for (int ch = 0; ch < 2; ch++) begin
            rd(ch, ecp_pkg::REG_CFG, c1);
            `CHK(c1[15:0], ecp_pkg::CFG_RESET)
            rd(ch, ecp_pkg::REG_STAT, c1);
            `CHK(c1, 32'h0)
            MODEL.pulse(ch, 3);
            cnt(ch, c1);
            `CHK(c1, 32'h0)
        end
        rd(1, 8'h30, c1);
        `CHK(c1, 32'h0)
    endtask : t_reset
    task automatic t_updn;
        go(0, f(1, ecp_pkg::CFG_EDGE_FALL) | f(1, ecp_pkg::CFG_DIR_LSB));
        cnt(0, c1);
        `CHK(c1, 32'h0)
        MODEL.pulse(0, 6);
        cnt(0, c1);
        `CHK(c1[31:8], 24'hffffff)
        `CHK(tc_seen > 0, 1'h1)
        step(0, 4, 32'hfffffffc);
        step(0, 0, 32'h0);
    endtask : t_updn
    task automatic t_dir;
        MODEL.lv(0, 1'h0, 1'h1);
        go(0, f(2, ecp_pkg::CFG_DIR_LSB));
        // Arm empties the third-edge pipeline; two edges refill it
        MODEL.pulse(0, 2);
        step(0, 4, 32'h4);
        MODEL.lv(0, 1'h0, 1'h0);
        MODEL.pulse(0, 4);
        step(0, 4, 32'hfffffffc);
    endtask : t_dir
    task automatic t_presc;
        int np[3] = '{2, 4, 16};
        for (int i = 0; i < 3; i++) begin
            go(0, f(i, ecp_pkg::CFG_PRE_LSB));
            MODEL.pulse(0, 2);
            step(0, np[i], 32'h2);
        end
        go(0, f(1, ecp_pkg::CFG_SRC_LSB) | f(2, ecp_pkg::CFG_PRE_LSB));
        // Timebase runs freely; an undivided count moves about ten
        cnt(0, c1);
        cnt(0, c2);
        `CHK(c2 - c1 > 32'h5, 1'h1)
        `CHK(c2 - c1 < 32'h10, 1'h1)
    endtask : t_presc
    task automatic t_pause;
        for (int hi = 0; hi < 2; hi++) begin
            MODEL.lv(0, 1'(hi), 1'h1);
            go(0, f(1, ecp_pkg::CFG_PAUSE_EN) | f(hi, ecp_pkg::CFG_PAUSE_HI));
            MODEL.pulse(0, 4);
            step(0, 4, 32'h0);
            MODEL.lv(0, 1'(1 - hi), 1'h1);
            MODEL.pulse(0, 4);
            step(0, 4, 32'h4);
        end
    endtask : t_pause
    task automatic t_buf;
        go(0, f(1, ecp_pkg::CFG_BUF_EN) | f(1, ecp_pkg::CFG_SCLK_FALL));
        MODEL.pulse(0, 4);
        MODEL.smp_set(0, 1'h1);
        `CHK(vld[0], 1'h0)
        MODEL.smp_set(0, 1'h0);
        `CHK(vld[0], 1'h1)
        c1 = sdat[0];
        `CHK(c1 != 32'h0, 1'h1)
        MODEL.pulse(0, 4);
        MODEL.smp_set(0, 1'h1);
        MODEL.smp_set(0, 1'h0);
        rd(0, ecp_pkg::REG_STAT, c2);
        `CHK(c2[6:4], 3'h2)
        pop;
        `CHK(sdat[0] - c1, 32'h4)
        pop;
        `CHK(vld[0], 1'h0)
    endtask : t_buf
    task automatic t_casc;
        go(1, f(4, ecp_pkg::CFG_SRC_LSB));
        go(0, f(1, ecp_pkg::CFG_DIR_LSB));
        MODEL.pulse(0, 6);
        cnt(1, c1);
        `CHK(c1, 32'hffffffff)
        `CHK(iout[1], 1'h1)
    endtask : t_casc
    task automatic t_hwarm;
        wr(0, ecp_pkg::REG_CTRL, f(1, ecp_pkg::CTRL_DISARM));
        wr(0, ecp_pkg::REG_CFG,
            f(1, ecp_pkg::CFG_HWARM_EN) | f(1, ecp_pkg::CFG_SLOW_SYNC));
        step(0, 4, 32'h0);
        MODEL.hw_arm(0);
        rd(0, ecp_pkg::REG_STAT, c1);
        `CHK(c1[0], 1'h1)
        MODEL.pulse(0, 4);
        step(0, 4, 32'h4);
    endtask : t_hwarm
    ////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        rst = 1'h1;
        cyc = 1'h0;
        stb = 1'h0;
        wen = 1'h0;
        adr = 8'h0;
        sel = 4'h0;
        wdat = 32'h0;
        rdy = 2'h0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        t_reset;
        t_updn;
        t_dir;
        t_presc;
        t_pause;
        t_buf;
        t_casc;
        t_hwarm;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        conclude;
    end
endmodule : edge_counter_with_prescaler_bench
`default_nettype wire
